// File: rtl/image_stats_pkg.sv
// constants and types shared by the image statistics and pixel grabber block
package image_stats_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // array geometry
    localparam int ARRAY_ROWS  = 19;
    localparam int ARRAY_COLS  = 19;
    localparam int PIXEL_BITS  = 7;
    localparam int INDEX_BITS  = 9;
    localparam int COORD_BITS  = 5;
    localparam int SUM_WIDTH   = 17;
    localparam int SUM_LSB     = 8;
    localparam int VALID_BIT   = 7;

    localparam logic [INDEX_BITS-1:0] PIXEL_COUNT = 9'h169;
    localparam logic [INDEX_BITS-1:0] FIRST_INDEX = 9'h000;
    localparam logic [INDEX_BITS-1:0] TOP_LEFT_INDEX = 9'h156;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] ADDR_PEAK_PIXEL_LEVEL    = 8'h0A;
    localparam logic [7:0] ADDR_PIXEL_SUM_UPPER     = 8'h0B;
    localparam logic [7:0] ADDR_LOWEST_PIXEL_LEVEL  = 8'h0C;
    localparam logic [7:0] ADDR_SINGLE_PIXEL_CAPTURE = 8'h0D;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] RESET_VALUE  = 8'h00;
    localparam logic [7:0] UNMAPPED_VAL = 8'h00;
    localparam logic [PIXEL_BITS-1:0] PIXEL_ZERO = 7'h00;
    localparam logic [PIXEL_BITS-1:0] PIXEL_FULL = 7'h7F;
    localparam logic [SUM_WIDTH-1:0]  SUM_ZERO   = 17'h00000;

    ////////////////////////////////////////////////////////////////////////////
    // grabber states
    typedef enum logic [1:0] {
        GRAB_WAIT_FRAME,
        GRAB_ARMED,
        GRAB_HOLDING
    } grab_state_e;

endpackage : image_stats_pkg

// File: rtl/frame_stats_accum.sv
// running peak, lowest and sum of the pixels of one image
`timescale 1ns/1ps
module frame_stats_accum
    import image_stats_pkg::*;
#(
    parameter int PIX_W = PIXEL_BITS,
    parameter int SUM_W = SUM_WIDTH
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             frameStart,
    input  wire logic             frameEnd,
    input  wire logic             pixValid,
    input  wire logic [PIX_W-1:0] pixLevel,
    output logic      [PIX_W-1:0] runPeak,
    output logic      [PIX_W-1:0] runLow,
    output logic      [SUM_W-1:0] runSum,
    output logic                  statsDone
);

    logic [PIX_W-1:0] peak_q;
    logic [PIX_W-1:0] low_q;
    logic [SUM_W-1:0] sum_q;
    logic             done_q;

    ////////////////////////////////////////////////////////////////////////////
    // extremes, restarted at each image
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            peak_q <= {PIX_W{1'b0}};
            low_q  <= {PIX_W{1'b1}};
        end else if (frameStart) begin
            peak_q <= {PIX_W{1'b0}};
            low_q  <= {PIX_W{1'b1}};
        end else if (pixValid) begin
            if (pixLevel > peak_q) begin
                peak_q <= pixLevel;
            end
            if (pixLevel < low_q) begin
                low_q <= pixLevel;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // unsigned sum of all pixels
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sum_q <= {SUM_W{1'b0}};
        end else if (frameStart) begin
            sum_q <= {SUM_W{1'b0}};
        end else if (pixValid) begin
            sum_q <= sum_q + {{(SUM_W-PIX_W){1'b0}}, pixLevel};
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= 1'b0;
        end else begin
            done_q <= frameEnd;
        end
    end

    assign runPeak   = peak_q;
    assign runLow    = low_q;
    assign runSum    = sum_q;
    assign statsDone = done_q;

endmodule : frame_stats_accum

// File: rtl/image_stats_pixel_grabber.sv
// frame statistics registers and single pixel grabber
//
// Contract
// - after each image the peak register holds that image's largest pixel, bit 7 reading zero.
// - all pixels of an image are summed into an unsigned 17-bit accumulator shown through a read-only register.
// - the sum register shows only bits 15 down to 8 of the sum, so the average is that value divided by 1.41.
// - after each image the lowest register holds that image's smallest pixel, bit 7 reading zero.
// - an armed grabber captures exactly one pixel per frame, the one picked by its index counter.
// - reading the grabber while it holds a pixel returns bit 7 set with the pixel, bumps the index and re-arms.
// - any write to the grabber resets the index and arms it to capture pixel zero from the next image.
// - indices run down each 19-pixel column, columns right to left, top row 342 at left and 0 at right.
// - the grabber reads zero after reset and is read/write; peak, lowest and sum are read-only, resetting to zero.
`timescale 1ns/1ps
module image_stats_pixel_grabber
    import image_stats_pkg::*;
#(
    parameter int ROWS = ARRAY_ROWS,
    parameter int COLS = ARRAY_COLS
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    // register port
    input  wire logic [7:0]            regAddr,
    input  wire logic [7:0]            regWrData,
    input  wire logic                  regWrEn,
    input  wire logic                  regRdEn,
    output logic      [7:0]            regRdData,
    // pixel stream from image acquisition
    input  wire logic                  frameStart,
    input  wire logic                  frameEnd,
    input  wire logic                  pixValid,
    input  wire logic [COORD_BITS-1:0] pixRow,
    input  wire logic [COORD_BITS-1:0] pixCol,
    input  wire logic [7:0]            pixData,
    // grabber status
    output logic      [INDEX_BITS-1:0] grabIndex,
    output logic                       grabHolding,
    output logic                       imageUploaded
);

    ////////////////////////////////////////////////////////////////////////////
    // coordinate decoding

    // column 0 is the left edge, row 0 the top
    function automatic logic [INDEX_BITS-1:0] pixel_index(
        input logic [COORD_BITS-1:0] row,
        input logic [COORD_BITS-1:0] col
    );
        logic [INDEX_BITS-1:0] colFromRight;
        logic [INDEX_BITS-1:0] product;
        colFromRight = INDEX_BITS'(COLS - 1) - {{(INDEX_BITS-COORD_BITS){1'b0}}, col};
        product      = INDEX_BITS'(colFromRight * INDEX_BITS'(ROWS));
        pixel_index  = product + {{(INDEX_BITS-COORD_BITS){1'b0}}, row};
    endfunction : pixel_index

    function automatic logic coord_inside(
        input logic [COORD_BITS-1:0] row,
        input logic [COORD_BITS-1:0] col
    );
        coord_inside = (row < COORD_BITS'(ROWS)) && (col < COORD_BITS'(COLS));
    endfunction : coord_inside

    function automatic logic addr_is(
        input logic [7:0] addr,
        input logic [7:0] target
    );
        addr_is = (addr == target);
    endfunction : addr_is

    ////////////////////////////////////////////////////////////////////////////
    // grabber and register field decoding

    function automatic logic is_holding(
        input grab_state_e state
    );
        is_holding = (state == GRAB_HOLDING);
    endfunction : is_holding

    // bit 7 of the level registers always reads zero
    function automatic logic [7:0] level_word(
        input logic [PIXEL_BITS-1:0] level
    );
        level_word = {1'b0, level};
    endfunction : level_word

    // index wraps after the last pixel of the array
    function automatic logic [INDEX_BITS-1:0] next_index(
        input logic [INDEX_BITS-1:0] index
    );
        if (index == PIXEL_COUNT - 9'h001) begin
            next_index = FIRST_INDEX;
        end else begin
            next_index = index + 9'h001;
        end
    endfunction : next_index

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [PIXEL_BITS-1:0] pixLevel;
    logic                  pixInside;
    logic [INDEX_BITS-1:0] pixIndex;
    logic                  pixUsable;

    logic [PIXEL_BITS-1:0] runPeak;
    logic [PIXEL_BITS-1:0] runLow;
    logic [SUM_WIDTH-1:0]  runSum;
    logic                  statsDone;

    logic [PIXEL_BITS-1:0] peak_q;
    logic [PIXEL_BITS-1:0] low_q;
    logic [7:0]            sumUpper_q;

    grab_state_e           state_q;
    grab_state_e           state_d;
    logic [INDEX_BITS-1:0] index_q;
    logic [INDEX_BITS-1:0] index_d;
    logic [PIXEL_BITS-1:0] held_q;
    logic [INDEX_BITS-1:0] uploads_q;
    logic                  frameOpen_q;
    logic                  holding_q;
    logic                  uploaded_q;

    logic                  grabWrite;
    logic                  grabRead;
    logic                  capture;
    logic                  deliver;

    logic [7:0]            rdData_q;
    logic [7:0]            rdData_d;

    ////////////////////////////////////////////////////////////////////////////
    // pixel stream qualification

    // only the low seven bits carry level, bit 7 is never stored
    assign pixLevel  = pixData[PIXEL_BITS-1:0];
    assign pixInside = coord_inside(pixRow, pixCol);
    assign pixIndex  = pixel_index(pixRow, pixCol);

    // pixels outside an open frame or outside the array are dropped
    assign pixUsable = pixValid && pixInside && frameOpen_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            frameOpen_q <= 1'b0;
        end else if (frameStart) begin
            frameOpen_q <= 1'b1;
        end else if (frameEnd) begin
            frameOpen_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // image statistics

    frame_stats_accum #(
        .PIX_W (PIXEL_BITS),
        .SUM_W (SUM_WIDTH)
    ) i_frame_stats_accum (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .frameStart (frameStart),
        .frameEnd   (frameEnd),
        .pixValid   (pixUsable),
        .pixLevel   (pixLevel),
        .runPeak    (runPeak),
        .runLow     (runLow),
        .runSum     (runSum),
        .statsDone  (statsDone)
    );

    // published once the image has ended, held until the next one ends
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            peak_q <= PIXEL_ZERO;
        end else if (statsDone) begin
            peak_q <= runPeak;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            low_q <= PIXEL_ZERO;
        end else if (statsDone) begin
            low_q <= runLow;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sumUpper_q <= RESET_VALUE;
        end else if (statsDone) begin
            sumUpper_q <= runSum[SUM_LSB+7:SUM_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // grabber control

    assign grabWrite = regWrEn && addr_is(regAddr, ADDR_SINGLE_PIXEL_CAPTURE);
    assign grabRead  = regRdEn && addr_is(regAddr, ADDR_SINGLE_PIXEL_CAPTURE);

    // one pixel per frame: arming waits for a fresh frame start
    assign capture = (state_q == GRAB_ARMED) && pixUsable && (pixIndex == index_q);
    assign deliver = grabRead && is_holding(state_q);

    always_comb begin
        state_d = state_q;
        index_d = index_q;
        if (grabWrite) begin
            // written value is ignored, a write also beats a capture
            state_d = GRAB_WAIT_FRAME;
            index_d = FIRST_INDEX;
        end else begin
            case (state_q)
                GRAB_WAIT_FRAME: begin
                    if (frameStart) begin
                        state_d = GRAB_ARMED;
                    end
                end
                GRAB_ARMED: begin
                    if (capture) begin
                        state_d = GRAB_HOLDING;
                    end
                end
                GRAB_HOLDING: begin
                    if (deliver) begin
                        state_d = GRAB_WAIT_FRAME;
                        index_d = next_index(index_q);
                    end
                end
                default: begin
                    state_d = GRAB_WAIT_FRAME;
                end
            endcase
        end
    end

    // a read without a held pixel changes neither state nor index
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= GRAB_WAIT_FRAME;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            index_q <= FIRST_INDEX;
        end else begin
            index_q <= index_d;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            held_q <= PIXEL_ZERO;
        end else if (capture && !grabWrite) begin
            held_q <= pixLevel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // upload progress

    // counts valid deliveries since the last write, full image at 361
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            uploads_q <= FIRST_INDEX;
        end else if (grabWrite) begin
            uploads_q <= FIRST_INDEX;
        end else if (deliver && (uploads_q != PIXEL_COUNT)) begin
            uploads_q <= uploads_q + 9'h001;
        end
    end

    // status outputs straight from flip-flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            holding_q <= 1'b0;
        end else begin
            holding_q <= is_holding(state_d);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            uploaded_q <= 1'b0;
        end else if (grabWrite) begin
            uploaded_q <= 1'b0;
        end else if (deliver && (uploads_q == PIXEL_COUNT - 9'h001)) begin
            uploaded_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read path

    always_comb begin
        rdData_d = UNMAPPED_VAL;
        case (regAddr)
            ADDR_PEAK_PIXEL_LEVEL: begin
                rdData_d = level_word(peak_q);
            end
            ADDR_PIXEL_SUM_UPPER: begin
                rdData_d = sumUpper_q;
            end
            ADDR_LOWEST_PIXEL_LEVEL: begin
                rdData_d = level_word(low_q);
            end
            ADDR_SINGLE_PIXEL_CAPTURE: begin
                if (is_holding(state_q)) begin
                    rdData_d = {1'b1, held_q};
                end else begin
                    rdData_d = RESET_VALUE;
                end
            end
            default: begin
                rdData_d = UNMAPPED_VAL;
            end
        endcase
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdData_q <= RESET_VALUE;
        end else if (regRdEn) begin
            rdData_q <= rdData_d;
        end else begin
            rdData_q <= RESET_VALUE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign regRdData     = rdData_q;
    assign grabIndex     = index_q;
    assign grabHolding   = holding_q;
    assign imageUploaded = uploaded_q;

endmodule : image_stats_pixel_grabber

// File: verif/image_stats_pixel_grabber_asserts.sv
// port-level checks for the statistics registers and the pixel grabber
`timescale 1ns/1ps
module image_stats_pixel_grabber_asserts
    import image_stats_pkg::*;
#(
    parameter int ROWS = ARRAY_ROWS,
    parameter int COLS = ARRAY_COLS
) (
    input wire logic                  clk_sys,
    input wire logic                  rst_n,
    input wire logic [7:0]            regAddr,
    input wire logic [7:0]            regWrData,
    input wire logic                  regWrEn,
    input wire logic                  regRdEn,
    input wire logic [7:0]            regRdData,
    input wire logic                  frameStart,
    input wire logic                  frameEnd,
    input wire logic                  pixValid,
    input wire logic [COORD_BITS-1:0] pixRow,
    input wire logic [COORD_BITS-1:0] pixCol,
    input wire logic [7:0]            pixData,
    input wire logic [INDEX_BITS-1:0] grabIndex,
    input wire logic                  grabHolding,
    input wire logic                  imageUploaded
);
    logic                  grabAcc;
    logic [INDEX_BITS-1:0] pixIdx;
    assign grabAcc = (regRdEn || regWrEn) && regAddr == ADDR_SINGLE_PIXEL_CAPTURE;
    assign pixIdx  = INDEX_BITS'((COLS - 1 - int'(pixCol)) * ROWS + int'(pixRow));
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    rd_idle_zero_a: assert property (!$past(regRdEn) |-> regRdData == 8'h00)
        else $error("read data not zero outside a read cycle");
    peak_msb_zero_a: assert property ($past(regRdEn && regAddr == ADDR_PEAK_PIXEL_LEVEL) |-> !regRdData[7])
        else $error("peak register bit 7 set");
    low_msb_zero_a: assert property ($past(regRdEn && regAddr == ADDR_LOWEST_PIXEL_LEVEL) |-> !regRdData[7])
        else $error("lowest register bit 7 set");
    grab_valid_a: assert property ($past(grabAcc && !regWrEn && grabHolding) |-> regRdData[VALID_BIT])
        else $error("held pixel read without valid flag");
    grab_empty_a: assert property ($past(grabAcc && !regWrEn && !grabHolding) |-> regRdData == 8'h00)
        else $error("empty grabber read not zero");
    grab_advance_a: assert property (grabAcc && !regWrEn && grabHolding |=> !grabHolding &&
        grabIndex == (($past(grabIndex) == PIXEL_COUNT - 1) ? FIRST_INDEX : $past(grabIndex) + 9'h001))
        else $error("grabber read did not advance and re-arm");
    index_stable_a: assert property (!(grabAcc && (regWrEn || grabHolding)) |=> $stable(grabIndex))
        else $error("grab index moved without a valid read or write");
    write_rearm_a: assert property (regWrEn && regAddr == ADDR_SINGLE_PIXEL_CAPTURE |=>
        grabIndex == FIRST_INDEX && !grabHolding)
        else $error("grabber write did not reset index");
    hold_keep_a: assert property (grabHolding && !grabAcc |=> grabHolding)
        else $error("held pixel lost without access");
    capture_pos_a: assert property ($rose(grabHolding) |-> $past(pixValid && pixIdx == grabIndex))
        else $error("capture not at indexed pixel");
    upload_done_a: assert property ($rose(imageUploaded) |->
        $past(grabAcc && !regWrEn && grabHolding) && grabIndex == FIRST_INDEX)
        else $error("upload flag without final valid read");
    capture_c: cover property ($rose(grabHolding));
    upload_c: cover property ($rose(imageUploaded));
    rearm_c: cover property (regWrEn && regAddr == ADDR_SINGLE_PIXEL_CAPTURE && grabHolding);
endmodule : image_stats_pixel_grabber_asserts

bind image_stats_pixel_grabber image_stats_pixel_grabber_asserts #(.ROWS(ROWS), .COLS(COLS))
    i_image_stats_pixel_grabber_asserts (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .frameStart(frameStart), .frameEnd(frameEnd), .pixValid(pixValid), .pixRow(pixRow), .pixCol(pixCol),
    .pixData(pixData), .grabIndex(grabIndex), .grabHolding(grabHolding), .imageUploaded(imageUploaded));

// File: verif/test_image_stats_pixel_grabber.sv
// self-checking bench for the statistics registers and the pixel grabber
`timescale 1ns/1ps
module test_image_stats_pixel_grabber;
    import image_stats_pkg::*;
    logic                  clk_sys = 1'b0, rst_n = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
    logic                  frameStart = 1'b0, frameEnd = 1'b0, pixValid = 1'b0;
    logic [7:0]            regAddr = 8'h00, regWrData = 8'h00, pixData = 8'h00, regRdData, rd;
    logic [COORD_BITS-1:0] pixRow = 5'h00, pixCol = 5'h00;
    logic [INDEX_BITS-1:0] grabIndex;
    logic                  grabHolding, imageUploaded;
    int                    error_cnt = 0, samples_checked = 0, cycles = 0;

    always #5 clk_sys = ~clk_sys;

    image_stats_pixel_grabber i_image_stats_pixel_grabber (.clk_sys(clk_sys), .rst_n(rst_n),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .frameStart(frameStart), .frameEnd(frameEnd), .pixValid(pixValid),
        .pixRow(pixRow), .pixCol(pixCol), .pixData(pixData), .grabIndex(grabIndex),
        .grabHolding(grabHolding), .imageUploaded(imageUploaded));

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        if (error_cnt == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk_sys);
        regWrEn <= 1'b0;
        #1;
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        @(posedge clk_sys);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk_sys);
        regRdEn <= 1'b0;
        #1 rd = regRdData;
    endtask : rdr

    ////////////////////////////////////////////////////////////////////////////
    // pixel level pattern, distinct down every column
    function automatic logic [6:0] pv(input int r, input int c);
        return 7'((r * 7 + c * 3 + 1) % 128);
    endfunction : pv

    task automatic pix(input int r, input int c);
        @(posedge clk_sys);
        pixValid <= 1'b1;
        pixRow <= 5'(r);
        pixCol <= 5'(c);
        pixData <= {1'b1, pv(r, c)};
    endtask : pix

    task automatic fstart;
        @(posedge clk_sys);
        frameStart <= 1'b1;
        @(posedge clk_sys);
        frameStart <= 1'b0;
    endtask : fstart

    task automatic fend;
        @(posedge clk_sys);
        pixValid <= 1'b0;
        frameEnd <= 1'b1;
        @(posedge clk_sys);
        frameEnd <= 1'b0;
    endtask : fend

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        for (int a = 8'h09; a <= 8'h0E; a++) begin
            rdr(8'(a));
            check(rd, 16'h0000);
        end
    endtask : t_reset

    // full image with pixel bit 7 set, stats writes ignored
    task automatic t_stats;
        int mx;
        int mn;
        int sum;
        mx = 0;
        mn = 127;
        sum = 0;
        fstart();
        for (int c = 0; c < 19; c++) begin
            for (int r = 0; r < 19; r++) begin
                pix(r, c);
                mx = (pv(r, c) > mx) ? pv(r, c) : mx;
                mn = (pv(r, c) < mn) ? pv(r, c) : mn;
                sum += pv(r, c);
            end
        end
        fend();
        repeat (3) @(posedge clk_sys);
        wr(ADDR_PEAK_PIXEL_LEVEL, 8'h55);
        wr(ADDR_PIXEL_SUM_UPPER, 8'hFF);
        wr(ADDR_LOWEST_PIXEL_LEVEL, 8'h7F);
        rdr(ADDR_PEAK_PIXEL_LEVEL);
        check(rd, 16'(mx));
        rdr(ADDR_PIXEL_SUM_UPPER);
        check(rd, 16'((sum >> 8) & 255));
        rdr(ADDR_LOWEST_PIXEL_LEVEL);
        check(rd, 16'(mn));
        rdr(ADDR_SINGLE_PIXEL_CAPTURE);
        check(rd, {9'h001, pv(0, 18)});
        check(grabIndex, 16'h0001);
        rdr(ADDR_SINGLE_PIXEL_CAPTURE);
        check(rd, 16'h0000);
        check(grabIndex, 16'h0001);
    endtask : t_stats

    // capture held, then a write throws it away; second image stats, outside pixels dropped
    task automatic t_rewrite;
        int mx;
        int mn;
        int sum;
        mx = 0;
        mn = 127;
        sum = 0;
        fstart();
        for (int r = 0; r < 19; r++) begin
            pix(r, 18);
            mx = (pv(r, 18) > mx) ? pv(r, 18) : mx;
            mn = (pv(r, 18) < mn) ? pv(r, 18) : mn;
            sum += pv(r, 18);
        end
        pix(23, 31);
        pix(10, 19);
        fend();
        check(grabHolding, 16'h0001);
        wr(ADDR_SINGLE_PIXEL_CAPTURE, 8'h3C);
        check({grabHolding, grabIndex}, 16'h0000);
        rdr(ADDR_SINGLE_PIXEL_CAPTURE);
        check(rd, 16'h0000);
        rdr(ADDR_PEAK_PIXEL_LEVEL);
        check(rd, 16'(mx));
        rdr(ADDR_LOWEST_PIXEL_LEVEL);
        check(rd, 16'(mn));
        rdr(ADDR_PIXEL_SUM_UPPER);
        check(rd, 16'((sum >> 8) & 255));
    endtask : t_rewrite

    // whole image, one column plus a transposed decoy per frame
    task automatic t_upload;
        int col;
        int row;
        for (int k = 0; k < 361; k++) begin
            col = 18 - k / 19;
            row = k % 19;
            fstart();
            for (int r = 0; r < 19; r++)
                pix(r, col);
            pix(col, row);
            fend();
            rdr(ADDR_SINGLE_PIXEL_CAPTURE);
            check(rd, {9'h001, pv(row, col)});
        end
        check({imageUploaded, grabIndex}, 16'h0200);
    endtask : t_upload

    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_stats();
        t_rewrite();
        t_upload();
        test_done();
    end
endmodule : test_image_stats_pixel_grabber
